// ### eitm_pkg.sv
package eitm_pkg;
    // sizes of the event space and the request queue
    localparam int NUM_OUT = 32;
    localparam int NUM_IN = 2;
    localparam int NUM_EVT = 66;
    localparam int IN_EVT_BASE = 64;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int TASK_W = 8;
    localparam int FUNC_W = 5;
    localparam int IDX_W = 7;

    // register byte offsets on the apb bus
    localparam logic [11:0] ADDR_OUT_OFS = 12'h000;
    localparam logic [11:0] ADDR_OUT_EN_LO = 12'h004;
    localparam logic [11:0] ADDR_OUT_EN_HI = 12'h008;
    localparam logic [11:0] ADDR_IN_EN = 12'h00c;
    localparam logic [11:0] ADDR_IN_OFS = 12'h010;
    localparam logic [11:0] ADDR_IN_FUNC = 12'h014;
    localparam logic [11:0] ADDR_STATUS = 12'h018;

    // field positions
    localparam int FUNC1_LSB = 8;
    localparam int STAT_ERR_BIT = 0;
    localparam int STAT_CNT_LSB = 8;

    // function codes that trigger on the falling edge of an input
    localparam logic [FUNC_W-1:0] FUNC_FALL_MAX = 5'h0e;

    // reset values
    localparam logic [11:0] RST_OFS = 12'h000;
    localparam logic [15:0] RST_EN16 = 16'h0000;
    localparam logic [1:0] RST_IN_EN = 2'h0;
    localparam logic [FUNC_W-1:0] RST_FUNC = 5'h00;

    typedef struct packed {
        logic [11:0] outOfsBcd;
        logic [31:0] outEn;
        logic [1:0] inEn;
        logic [11:0] inOfsBcd;
        logic [FUNC_W-1:0] inFunc0;
        logic [FUNC_W-1:0] inFunc1;
    } eitm_cfg_t;

    typedef struct packed {
        logic valid;
        logic [TASK_W-1:0] num;
    } eitm_task_t;
endpackage

// ### eitm_task_mapper.sv
// Function
// (R1) all 32 pattern bits map in order onto consecutive task numbers, output 0 at the output offset.
// (R2) bit k requests offset plus 2k on a rising edge and offset plus 2k plus one on a falling edge.
// (R3) output requests come from transitions of the internal output pattern, not from pins.
// (R4) the host keeps the output offset at or below 192 so tasks stay within 0 to 255.
// (R5) the host writes the output offset in binary-coded decimal.
// (R6) the host supplies a handler for both tasks of every enabled output.
// (R7) each enabled input requests on one edge, falling for codes 2,4,...,14 and rising otherwise.
// (R8) the input enable is two bits, bit 0 for input zero and bit 1 for input one, cleared at reset.
// (R9) input zero requests the input offset and input one requests that offset plus one.
// (R10) the host keeps the input offset at or below 252.
// (R11) simultaneous requests are queued first in, first out and issued in arrival order.
// (R12) a request meeting a full queue raises the queue-full error.
// (R13) overlapping output and input task ranges raise no error.
// (R14) output enables are 32 bits in a low and a high half word, all cleared at reset.
// (R15) a request meeting a full queue is dropped and requests leave one at a time from the head.
module eitm_task_mapper (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] outPattern,
    input wire logic digitalInputZero,
    input wire logic digitalInputOne,
    output eitm_pkg::eitm_task_t taskReq,
    input wire logic taskReady,
    output logic queueFullErr
);
    function automatic logic [7:0] bcdToBin(input logic [11:0] b);
        logic [9:0] s;
        s = 10'(b[11:8]) * 10'd100 + 10'(b[7:4]) * 10'd10 + 10'(b[3:0]);
        return s[7:0];
    endfunction

    function automatic logic isFallCode(input logic [eitm_pkg::FUNC_W-1:0] f);
        return (f != '0) && !f[0] && (f <= eitm_pkg::FUNC_FALL_MAX);
    endfunction

    eitm_pkg::eitm_cfg_t cfg, next_cfg;
    logic errFlag, next_errFlag;
    logic [31:0] next_prdata;
    logic [31:0] prevPattern;
    logic [1:0] inSync1, inSync2, prevIn;
    logic [eitm_pkg::NUM_EVT-1:0] evt, pend, next_pend, grant;
    logic [7:0] fifoMem [eitm_pkg::FIFO_DEPTH];
    logic [eitm_pkg::PTR_W-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [eitm_pkg::CNT_W-1:0] count, next_count;
    logic [eitm_pkg::IDX_W-1:0] pickIdx;
    logic [7:0] pickTask, outOfs, inOfs;
    logic push, pop, full, lostAny, dropNow;
    logic wrAccess, addrHit;

    assign outOfs = bcdToBin(cfg.outOfsBcd); // [R5]
    assign inOfs = bcdToBin(cfg.inOfsBcd);

    // apb: zero wait states, read data captured in the setup cycle
    assign pready = 1'b1;
    assign wrAccess = psel && penable && pwrite;
    always_comb begin
        case (paddr)
            eitm_pkg::ADDR_OUT_OFS, eitm_pkg::ADDR_OUT_EN_LO, eitm_pkg::ADDR_OUT_EN_HI, eitm_pkg::ADDR_IN_EN,
            eitm_pkg::ADDR_IN_OFS, eitm_pkg::ADDR_IN_FUNC, eitm_pkg::ADDR_STATUS: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addrHit;

    // register file next values
    always_comb begin
        next_cfg = cfg;
        next_prdata = prdata;
        if (wrAccess) begin
            case (paddr)
                eitm_pkg::ADDR_OUT_OFS: next_cfg.outOfsBcd = pwdata[11:0];
                eitm_pkg::ADDR_OUT_EN_LO: next_cfg.outEn[15:0] = pwdata[15:0]; // [R14]
                eitm_pkg::ADDR_OUT_EN_HI: next_cfg.outEn[31:16] = pwdata[15:0]; // [R14]
                eitm_pkg::ADDR_IN_EN: next_cfg.inEn = pwdata[1:0]; // [R8]
                eitm_pkg::ADDR_IN_OFS: next_cfg.inOfsBcd = pwdata[11:0];
                eitm_pkg::ADDR_IN_FUNC: begin
                    next_cfg.inFunc0 = pwdata[eitm_pkg::FUNC_W-1:0];
                    next_cfg.inFunc1 = pwdata[eitm_pkg::FUNC1_LSB +: eitm_pkg::FUNC_W];
                end
                default: ;
            endcase
        end
        if (psel && !penable) begin
            next_prdata = '0;
            case (paddr)
                eitm_pkg::ADDR_OUT_OFS: next_prdata[11:0] = cfg.outOfsBcd;
                eitm_pkg::ADDR_OUT_EN_LO: next_prdata[15:0] = cfg.outEn[15:0];
                eitm_pkg::ADDR_OUT_EN_HI: next_prdata[15:0] = cfg.outEn[31:16];
                eitm_pkg::ADDR_IN_EN: next_prdata[1:0] = cfg.inEn;
                eitm_pkg::ADDR_IN_OFS: next_prdata[11:0] = cfg.inOfsBcd;
                eitm_pkg::ADDR_IN_FUNC: begin
                    next_prdata[eitm_pkg::FUNC_W-1:0] = cfg.inFunc0;
                    next_prdata[eitm_pkg::FUNC1_LSB +: eitm_pkg::FUNC_W] = cfg.inFunc1;
                end
                eitm_pkg::ADDR_STATUS: begin
                    next_prdata[eitm_pkg::STAT_ERR_BIT] = errFlag;
                    next_prdata[eitm_pkg::STAT_CNT_LSB +: eitm_pkg::CNT_W] = count;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            cfg <= '{eitm_pkg::RST_OFS, {eitm_pkg::RST_EN16, eitm_pkg::RST_EN16}, eitm_pkg::RST_IN_EN,
                     eitm_pkg::RST_OFS, eitm_pkg::RST_FUNC, eitm_pkg::RST_FUNC};
            prdata <= '0;
        end else begin
            cfg <= next_cfg;
            prdata <= next_prdata;
        end
    end

    // edge history; pins pass two flops, the pattern is already on this clock
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            prevPattern <= '0;
            inSync1 <= '0;
            inSync2 <= '0;
            prevIn <= '0;
        end else begin
            prevPattern <= outPattern;
            inSync1 <= {digitalInputOne, digitalInputZero};
            inSync2 <= inSync1;
            prevIn <= inSync2;
        end
    end

    // one event bit per task slot: 2k rising, 2k+1 falling, then the inputs
    for (genvar k = 0; k < eitm_pkg::NUM_OUT; k++) begin : g_out
        assign evt[2*k] = cfg.outEn[k] && outPattern[k] && !prevPattern[k]; // [R3]
        assign evt[2*k+1] = cfg.outEn[k] && !outPattern[k] && prevPattern[k]; // [R3]
    end
    for (genvar j = 0; j < eitm_pkg::NUM_IN; j++) begin : g_in
        logic fall;
        assign fall = isFallCode(j == 0 ? cfg.inFunc0 : cfg.inFunc1);
        assign evt[eitm_pkg::IN_EVT_BASE+j] = cfg.inEn[j] && // [R8]
            (fall ? (prevIn[j] && !inSync2[j]) : (inSync2[j] && !prevIn[j])); // [R7]
    end

    // lowest pending slot goes first; one queue write per cycle
    always_comb begin
        pickIdx = '0;
        for (int i = eitm_pkg::NUM_EVT - 1; i >= 0; i--) begin
            if (pend[i]) pickIdx = 7'(i);
        end
    end
    assign push = |pend;
    assign grant = push ? ({{(eitm_pkg::NUM_EVT-1){1'b0}}, 1'b1} << pickIdx) : '0;
    assign pickTask = (pickIdx < 7'(eitm_pkg::IN_EVT_BASE)) ? outOfs + {2'h0, pickIdx[5:0]} // [R1] [R2]
                                                          : inOfs + {7'h00, pickIdx[0]}; // [R9]
    assign full = (count == 4'(eitm_pkg::FIFO_DEPTH));
    assign pop = taskReq.valid && taskReady;
    assign dropNow = push && full; // [R15]
    assign lostAny = |(evt & pend & ~grant);

    // queue and error flag; set beats a clear in the same cycle, overlap never errors [R13]
    always_comb begin
        next_pend = (pend & ~grant) | evt; // [R11]
        next_wptr = wptr;
        next_rptr = rptr;
        next_count = count;
        next_errFlag = errFlag;
        if (wrAccess && paddr == eitm_pkg::ADDR_STATUS && pwdata[eitm_pkg::STAT_ERR_BIT]) next_errFlag = 1'b0;
        if (dropNow || lostAny) next_errFlag = 1'b1; // [R12]
        if (push && !full) next_wptr = wptr + 3'h1;
        if (pop) next_rptr = rptr + 3'h1; // [R15]
        next_count = count + 4'(push && !full) - 4'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pend <= '0;
            wptr <= '0;
            rptr <= '0;
            count <= '0;
            errFlag <= 1'b0;
        end else begin
            pend <= next_pend;
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
            errFlag <= next_errFlag;
            if (push && !full) fifoMem[wptr] <= pickTask; // [R11]
        end
    end

    assign taskReq.valid = (count != '0);
    assign taskReq.num = fifoMem[rptr];
    assign queueFullErr = errFlag;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_full_push;
        push && full;
    endsequence

    chk_out_rise_pend: assert property (cfg.outEn[0] && outPattern[0] && !prevPattern[0] |=> pend[0]) // [R3]
        else $error("enabled rising pattern bit did not become pending");
    chk_task_number: assert property (push && !full && pickIdx < 7'd64 |=>
        fifoMem[$past(wptr)] == 8'($past(outOfs) + 8'($past(pickIdx)))) // [R2]
        else $error("queued output task number wrong");
    chk_in_fall_code: assert property (cfg.inEn[0] && isFallCode(cfg.inFunc0) && !pend[64]
        && inSync2[0] && !prevIn[0] |=> !pend[64]) // [R7]
        else $error("falling-code input fired on rising edge");
    chk_enables_reset: assert property (!$past(nrst) |-> cfg.outEn == '0 && cfg.inEn == '0) // [R14]
        else $error("enables not cleared after reset");
    chk_in_task_one: assert property (push && pickIdx == 7'd65 |-> pickTask == 8'(inOfs + 8'h01)) // [R9]
        else $error("input one task number wrong");
    chk_fifo_order: assert property (pop |=> rptr == 3'($past(rptr) + 3'h1) && count == $past(count)
        + 4'($past(push && !full)) - 4'h1) // [R11]
        else $error("queue head did not advance by one");
    chk_full_err: assert property (s_full_push |=> errFlag [*2]) // [R12]
        else $error("full queue push did not raise error");
    chk_drop_full: assert property (s_full_push ##0 !pop |=> wptr == $past(wptr)) // [R15]
        else $error("push into full queue was written");
    chk_no_spurious: assert property (!errFlag && !dropNow && !lostAny |=> !errFlag) // [R13]
        else $error("error raised without queue overflow");
endmodule // eitm_task_mapper

// ### eitm_host_model.sv
// behavioural host that runs numbered tasks; it can answer at once or stall to back the queue up
module eitm_host_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire eitm_pkg::eitm_task_t taskReq,
    input wire logic stall,
    output logic taskReady,
    output logic took,
    output logic [7:0] tookNum
);
    timeunit 1ns;
    timeprecision 1ns;
    // ready changes only after an edge, so a stall never cuts a handshake in half
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            taskReady <= 1'b0;
        end else begin
            taskReady <= !stall;
        end
    end
    // every task number has a handler here, even for edges that need no action
    always_ff @(posedge core_clk) begin
        took <= nrst && taskReq.valid && taskReady;
        tookNum <= taskReq.num;
    end
endmodule // eitm_host_model

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, dZero, dOne, taskReady, queueFullErr, stall, took, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, outPattern, rd;
    logic [7:0] tookNum;
    eitm_pkg::eitm_task_t taskReq;
    int mismatches = 0;
    int compares = 0;
    logic [7:0] log[$];
    // rows: bit index, new level, expected task with output offset ten
    logic [13:0] rows [6] = '{{5'h00, 1'h1, 8'h0a}, {5'h00, 1'h0, 8'h0b}, {5'h1f, 1'h1, 8'h48},
        {5'h1f, 1'h0, 8'h49}, {5'h03, 1'h1, 8'h10}, {5'h03, 1'h0, 8'h11}};
    logic [7:0] order [5] = '{8'h0a, 8'h0c, 8'h0e, 8'h10, 8'h0a};

    eitm_task_mapper eitm_task_mapper_inst (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .outPattern(outPattern), .digitalInputZero(dZero), .digitalInputOne(dOne), .taskReq(taskReq),
        .taskReady(taskReady), .queueFullErr(queueFullErr));
    eitm_host_model eitm_host_model_inst (.core_clk(core_clk), .nrst(nrst), .taskReq(taskReq), .stall(stall),
        .taskReady(taskReady), .took(took), .tookNum(tookNum));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // record every task the host ran, in order
    always @(posedge core_clk) begin
        if (took === 1'b1) begin
            log.push_back(tookNum);
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; the idle edge after it keeps two drives of psel out of one time step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        // no local wait limit: only the watchdog ends a transfer that never completes
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic close_out();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #4000000;
        mismatches++;
        close_out();
    end

    initial begin
        {nrst, psel, penable, pwrite, dZero, dOne, stall} = 7'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        outPattern = 32'h0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, eitm_pkg::ADDR_OUT_EN_HI, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, eitm_pkg::ADDR_IN_EN, 32'h0);
        chk(rd, 32'h0);
        chk(32'(taskReq.valid), 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, eitm_pkg::ADDR_OUT_OFS, 32'h10);
        apb(1'b1, eitm_pkg::ADDR_OUT_EN_LO, 32'hffff);
        apb(1'b1, eitm_pkg::ADDR_OUT_EN_HI, 32'hffff);
        apb(1'b0, eitm_pkg::ADDR_OUT_EN_HI, 32'h0);
        chk(rd, 32'hffff);
        apb(1'b1, eitm_pkg::ADDR_IN_OFS, 32'h30);
        apb(1'b1, eitm_pkg::ADDR_IN_EN, 32'h3);
        // single output edges, one task each
        foreach (rows[i]) begin
            log.delete();
            outPattern[rows[i][13:9]] <= rows[i][8];
            repeat (10) @(posedge core_clk);
            chk(32'(log.size()), 32'h1);
            chk(32'(log[0]), 32'(rows[i][7:0]));
        end
        // input function codes 0 to 16, input one kept on a falling-edge code
        for (int c = 0; c <= 16; c++) begin
            apb(1'b1, eitm_pkg::ADDR_IN_FUNC, {19'h0, 5'h02, 3'h0, 5'(c)});
            log.delete();
            dZero <= 1'b1;
            repeat (12) @(posedge core_clk);
            chk(32'(log.size()), (c % 2 == 0 && c >= 2 && c <= 14) ? 32'h0 : 32'h1);
            dZero <= 1'b0;
            repeat (12) @(posedge core_clk);
            chk(32'(log.size()), 32'h1);
            chk(32'(log[0]), 32'h1e);
        end
        log.delete();
        dOne <= 1'b1;
        repeat (12) @(posedge core_clk);
        dOne <= 1'b0;
        repeat (12) @(posedge core_clk);
        chk(32'(log.size()), 32'h1);
        chk(32'(log[0]), 32'h1f);
        // simultaneous edges with an input range overlapping the output range
        apb(1'b1, eitm_pkg::ADDR_IN_OFS, 32'h10);
        log.delete();
        stall <= 1'b1;
        outPattern <= 32'h0f;
        dZero <= 1'b1;
        repeat (12) @(posedge core_clk);
        apb(1'b0, eitm_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[11:0]), 32'h500);
        stall <= 1'b0;
        repeat (20) @(posedge core_clk);
        chk(32'(log.size()), 32'h5);
        foreach (order[i]) chk(32'(log[i]), 32'(order[i]));
        // 28 rises at once overrun the eight-deep queue
        log.delete();
        stall <= 1'b1;
        outPattern <= 32'hffffffff;
        repeat (40) @(posedge core_clk);
        apb(1'b0, eitm_pkg::ADDR_STATUS, 32'h0);
        chk(32'(rd[11:0]), 32'h801);
        chk(32'(queueFullErr), 32'h1);
        stall <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk(32'(log.size()), 32'h8);
        chk({16'h0, log[0], log[7]}, 32'h1220);
        apb(1'b1, eitm_pkg::ADDR_STATUS, 32'h1);
        apb(1'b0, eitm_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        // a second reset in mid-run clears the enables again
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, eitm_pkg::ADDR_OUT_EN_LO, 32'h0);
        chk(rd, 32'h0);
        // with enables cleared, the falling pattern edges may not queue a task; dZero is already high, so no pin edge is driven
        log.delete();
        outPattern <= 32'h0;
        dZero <= 1'b1;
        repeat (12) @(posedge core_clk);
        chk(32'(log.size()), 32'h0);
        chk(32'(queueFullErr), 32'h0);
        close_out();
    end
endmodule // tb_top
